/* verilog/spbr_pkg.sv */
// Constants and carrier types of the serial bus PHY register bank
// Overview of operation
// - Sixteen registers: fixed base, paged 8h-Fh
// - Eight pages map onto addresses 8h-Fh
// - Page selector lives in base register 7h
// - Base fields identical on every page
// - Reserved registers and fields read zero
// - Pages two through six read zero
// - Node identifier invalid from bus reset
// - Self-ID done sends register 0 status
// - Root clears on reset, set if root
// - Cable power bit mirrors sense input
// - Root holdoff survives bus resets only
// - Long request starts 166 us reset
// - Ongoing link traffic finishes before reset
// - Long request clears on any reset
// - Gap count drives arbitration gap timing
// - Gap updated by write or PHY_CONFIG
// - Gap 3Fh after hardware or double reset
// - Extended indicator reads 111b always
// - Port count follows two-port strap
// - Speed capability reads 010b always
// - Repeater delay field reads one
// - Interrupt flags reset zero except cable power drop (one), write-one clear
// - Short request starts 1.3 us reset
package spbr_pkg;
	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_PERIOD_NS   = 4;
	localparam int LONG_RESET_US   = 166;
	localparam int LONG_RESET_CYC  =
		(LONG_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHORT_RESET_NS  = 1300;
	localparam int SHORT_RESET_CYC =
		(SHORT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W       = 16;
	// ****************************************************
	// Register indices; byte address is index times four
	// ****************************************************
	localparam logic [3:0] IDX_NODE  = 4'h0;
	localparam logic [3:0] IDX_GAP   = 4'h1;
	localparam logic [3:0] IDX_PORTS = 4'h2;
	localparam logic [3:0] IDX_SPEED = 4'h3;
	localparam logic [3:0] IDX_LINK  = 4'h4;
	localparam logic [3:0] IDX_INTR  = 4'h5;
	localparam logic [3:0] IDX_RSVD  = 4'h6;
	localparam logic [3:0] IDX_PAGE  = 4'h7;
	localparam int         ADDR_W    = 8;
	// ****************************************************
	// Field positions (byte bit 0 is field position 0)
	// ****************************************************
	localparam int NODE_LSB  = 2;
	localparam int ROOT_BIT  = 1;
	localparam int CPS_BIT   = 0;
	localparam int RHB_BIT   = 7;
	localparam int LBR_BIT   = 6;
	localparam int LCTL_BIT  = 7;
	localparam int CONT_BIT  = 6;
	localparam int RES_BIT   = 7;
	localparam int SBR_BIT   = 6;
	localparam int CTO_BIT   = 5;
	localparam int CPD_BIT   = 4;
	localparam int STO_BIT   = 3;
	localparam int PEV_BIT   = 2;
	localparam int EAA_BIT   = 1;
	localparam int EMC_BIT   = 0;
	localparam int PAGE_LSB  = 5;
	// ****************************************************
	// Fixed values and reset values
	// ****************************************************
	localparam logic [2:0] EXT_VAL     = 3'h7;
	localparam logic [2:0] SPEED_VAL   = 3'h2;
	localparam logic [3:0] DELAY_VAL   = 4'h1;
	localparam logic [2:0] JITTER_VAL  = 3'h0;
	localparam logic [3:0] PORTS_TWO   = 4'h2;
	localparam logic [3:0] PORTS_ONE   = 4'h1;
	localparam logic [5:0] GAP_RESET   = 6'h3F;
	localparam logic       LCTL_RESET  = 1'h1;
	localparam logic       CPD_RESET   = 1'h1;
	localparam logic [2:0] PAGE_RSV_LO = 3'h2;
	localparam logic [2:0] PAGE_RSV_HI = 3'h6;
	localparam logic [2:0] PAGE_LAST   = 3'h7;
	// ****************************************************
	// Carriers
	// ****************************************************
	typedef struct packed {
		logic       busResetSeen; // Bus reset seen on cable
		logic       rootWon;      // Tree-ID made us root
		logic       selfIdDone;   // Self-ID finished
		logic [5:0] selfId;       // Address from self-ID
		logic       phyCfgValid;  // PHY_CONFIG with gap
		logic [5:0] phyCfgGap;    // Gap from that packet
		logic       linkBusy;     // Receive or transmit
		logic       cfgTimeout;   // Config time-out
		logic       stateTimeout; // State time-out
		logic       portEvent;    // Port status change
		logic       resumeStart;  // Resume began on a port
	} spbr_evt_t;
	typedef struct packed {
		logic       linkActive;
		logic       contender;
		logic [2:0] powerClass;
		logic       rootHoldoff;
		logic [5:0] gapCount;
		logic       resumeEnable;
		logic       arbAccel;
		logic       multispeed;
		logic [3:0] portSelect;
		logic       nodeIdValid;
	} spbr_ctrl_t;
	typedef struct packed {
		logic longReq;  // Long reset wanted
		logic shortReq; // Short reset wanted
		logic linkBusy; // Traffic in progress
	} spbr_rstreq_t;
endpackage : spbr_pkg

/* verilog/spbr_reset_engine.sv */
// Bus reset engine timing long and short resets
`timescale 1ns/1ns
module spbr_reset_engine #(
	parameter int LONG_CYCLES = spbr_pkg::LONG_RESET_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire spbr_pkg::spbr_rstreq_t req,
	output logic                      active,
	output logic                      isLong,
	output logic                      startPulse
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_DRIVE = 2'b10
	} spbr_eng_t;
	spbr_eng_t                        state_reg; // Engine state
	logic [spbr_pkg::RST_CNT_W-1:0]   cnt_reg;   // Cycles left
	logic                             go;        // Start now

	// Wait for traffic to end before starting
	// defer while busy
	assign go = (req.longReq | req.shortReq) & ~req.linkBusy;

	// ****************************************************
	// Sequencer
	// ****************************************************
	// Drive reset for the chosen duration
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg  <= ST_IDLE;
			cnt_reg    <= '0;
			isLong     <= 1'b0;
			startPulse <= 1'b0;
		end
		else
		begin
			startPulse <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
				begin
					if (go)
					begin
						state_reg  <= ST_DRIVE;
						startPulse <= 1'b1;
						isLong     <= req.longReq;
						cnt_reg    <= req.longReq ?
							spbr_pkg::RST_CNT_W'(LONG_CYCLES - 1) :
							spbr_pkg::RST_CNT_W'(
							spbr_pkg::SHORT_RESET_CYC - 1);
					end
				end
				ST_DRIVE:
				begin
					if (cnt_reg == '0)
						state_reg <= ST_IDLE;
					else
						cnt_reg <= cnt_reg - 1'b1;
				end
			endcase
		end
	end

	// Drive level is the one-hot drive bit, straight from the flop
	assign active = state_reg[1];
endmodule : spbr_reset_engine

/* verilog/spbr_page_store.sv */
// Byte storage behind the non-reserved register pages
`timescale 1ns/1ns
module spbr_page_store (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       wrEn,
	input  wire logic [1:0] slot,
	input  wire logic [2:0] idx,
	input  wire logic [7:0] wrData,
	output logic      [7:0] rdData
);
	localparam int ENTRIES = 24; // Three pages of eight
	logic [7:0] mem_reg [ENTRIES]; // Page bytes
	logic [4:0] sel;               // Flat entry index

	assign sel = {slot, idx};

	// ****************************************************
	// Storage
	// ****************************************************
	// One flop byte per entry, written by index
	for (genvar i = 0; i < ENTRIES; i++)
	begin : g_ent
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				mem_reg[i] <= 8'h00;
			else if (wrEn && sel == 5'(i))
				mem_reg[i] <= wrData;
		end
	end

	// Read by index; unused slot reads zero
	assign rdData = (sel < 5'(ENTRIES)) ? mem_reg[sel] : 8'h00;
endmodule : spbr_page_store

/* verilog/spbr_top.sv */
// Serial bus PHY register bank with APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module spbr_top #(
	parameter int LONG_CYCLES = spbr_pkg::LONG_RESET_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 cablePowerSense,
	input  wire logic                 twoPortStrap,
	input  wire logic                 contenderStrap,
	input  wire logic [2:0]           powerClassStrap,
	input  wire spbr_pkg::spbr_evt_t  evt,
	output spbr_pkg::spbr_ctrl_t      ctrl,
	output logic                      busResetDrive,
	output logic                      busResetLong,
	output logic                      statusXfer,
	output logic      [7:0]           statusData
);
	// ****************************************************
	// Reset release
	// ****************************************************
	logic rstMeta_reg; // First sync stage
	logic rstn_reg;    // Released reset

	// Release asynchronous reset through two flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_reg <= 1'b0;
			rstn_reg    <= 1'b0;
		end
		else
		begin
			rstMeta_reg <= 1'b1;
			rstn_reg    <= rstMeta_reg;
		end
	end

	// ****************************************************
	// State
	// ****************************************************
	logic [5:0] nodeId_reg;    // Node address
	logic       idValid_reg;   // Address valid
	logic       root_reg;      // Root flag
	logic       holdoff_reg;   // Root holdoff
	logic       longReq_reg;   // Long reset request
	logic       shortReq_reg;  // Short reset request
	logic [5:0] gap_reg;       // Gap count
	logic       noUpd_reg;     // Reset seen, no update
	logic       linkAct_reg;   // Link active control
	logic       contend_reg;   // Contender
	logic [2:0] pwr_reg;       // Power class
	logic       strapDone_reg; // Straps captured
	logic       resEn_reg;     // Resume event enable
	logic       cfgTo_reg;     // Config time-out flag
	logic       cpDrop_reg;    // Cable power drop flag
	logic       stTo_reg;      // State time-out flag
	logic       portEv_reg;    // Port event flag
	logic       eaa_reg;       // Arb acceleration
	logic       emc_reg;       // Multispeed concat
	logic [2:0] page_reg;      // Page selector
	logic [3:0] port_reg;      // Port selector
	logic       cpsPrev_reg;   // Last cable power level
	logic       ready_reg;     // APB ready
	logic [7:0] rdata_reg;     // APB read byte
	logic       err_reg;       // APB error
	logic       xfer_reg;      // Status transfer strobe
	logic [7:0] xdata_reg;     // Status transfer byte

	// ****************************************************
	// Bus decode
	// ****************************************************
	logic       badAddr;  // Outside map or misaligned
	logic [3:0] idx;      // Register index
	logic       wrFire;   // Write takes effect now
	logic [7:0] wd;       // Written byte
	logic       busReset; // Any bus reset
	logic       engStart; // Own reset started
	logic       engAct;   // Own reset driving
	logic       engLong;  // Own reset is long
	logic [7:0] pageRd;   // Paged store read
	logic [7:0] rdVal;    // Selected read byte
	logic       pagedHit; // Access to 8h-Fh
	logic       pageRsv;  // Reserved page chosen
	logic [1:0] slot;     // Store slot of page
	logic       w;        // Write to index

	assign idx     = paddr[5:2];
	assign badAddr = (paddr[7:6] != 2'h0) ||
		(paddr[1:0] != 2'h0);
	assign wd      = pwdata[7:0];
	// Write lands at the completing edge only
	assign wrFire  = psel & penable & ready_reg & pwrite &
		~badAddr & pstrb[0];
	assign busReset = evt.busResetSeen | engStart;

	assign pagedHit = idx[3];
	assign pageRsv  = (page_reg >= spbr_pkg::PAGE_RSV_LO) &&
		(page_reg <= spbr_pkg::PAGE_RSV_HI);
	assign slot = (page_reg == spbr_pkg::PAGE_LAST) ? 2'h2 :
		{1'b0, page_reg[0]};

	// ****************************************************
	// Read mux
	// ****************************************************
	// Assemble the addressed byte
	always_comb
	begin
		rdVal = 8'h00;
		if (pagedHit)
			rdVal = pageRsv ? 8'h00 : pageRd;
		else
		begin
			unique case (idx)
				spbr_pkg::IDX_NODE:
				begin
					rdVal[7:spbr_pkg::NODE_LSB] = nodeId_reg;
					rdVal[spbr_pkg::ROOT_BIT]   = root_reg;
					rdVal[spbr_pkg::CPS_BIT] = cablePowerSense;
				end
				spbr_pkg::IDX_GAP:
					rdVal = {holdoff_reg, longReq_reg, gap_reg};
				spbr_pkg::IDX_PORTS:
					rdVal = {spbr_pkg::EXT_VAL, 1'b0,
						twoPortStrap ? spbr_pkg::PORTS_TWO :
						spbr_pkg::PORTS_ONE};
				spbr_pkg::IDX_SPEED:
					rdVal = {spbr_pkg::SPEED_VAL, 1'b0,
						spbr_pkg::DELAY_VAL};
				spbr_pkg::IDX_LINK:
					rdVal = {linkAct_reg, contend_reg,
						spbr_pkg::JITTER_VAL, pwr_reg};
				spbr_pkg::IDX_INTR:
					rdVal = {resEn_reg, shortReq_reg, cfgTo_reg,
						cpDrop_reg, stTo_reg, portEv_reg,
						eaa_reg, emc_reg};
				spbr_pkg::IDX_PAGE:
					rdVal = {page_reg, 1'b0, port_reg};
				default:
					rdVal = 8'h00;
			endcase
		end
	end

	// ****************************************************
	// APB slave
	// ****************************************************
	// One wait state; error and zero for unmapped
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			ready_reg <= 1'b0;
			rdata_reg <= 8'h00;
			err_reg   <= 1'b0;
		end
		else
		begin
			ready_reg <= psel & penable & ~ready_reg;
			if (psel && penable && !ready_reg)
			begin
				rdata_reg <= badAddr ? 8'h00 : rdVal;
				err_reg   <= badAddr;
			end
			else
			begin
				rdata_reg <= 8'h00;
				err_reg   <= 1'b0;
			end
		end
	end

	assign w = wrFire & ~pagedHit;

	// ****************************************************
	// Node identity and root
	// ****************************************************
	// Capture address and send status on self-ID
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			nodeId_reg  <= 6'h00;
			idValid_reg <= 1'b0;
			xfer_reg    <= 1'b0;
			xdata_reg   <= 8'h00;
		end
		else
		begin
			xfer_reg <= 1'b0;
			if (evt.selfIdDone)
			begin
				nodeId_reg  <= evt.selfId;
				idValid_reg <= 1'b1;
				xfer_reg    <= 1'b1;
				xdata_reg   <= {evt.selfId, root_reg,
					cablePowerSense};
			end
			else if (busReset)
				idValid_reg <= 1'b0;
		end
	end

	// Root flag, set wins over bus reset clear
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
			root_reg <= 1'b0;
		else if (evt.rootWon)
			root_reg <= 1'b1;
		else if (busReset)
			root_reg <= 1'b0;
	end

	// ****************************************************
	// Register 1: holdoff, long request, gap
	// ****************************************************
	// Root holdoff survives bus reset
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
			holdoff_reg <= 1'b0;
		else if (w && idx == spbr_pkg::IDX_GAP)
			holdoff_reg <= wd[spbr_pkg::RHB_BIT];
	end

	// Long request cleared by any bus reset
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
			longReq_reg <= 1'b0;
		else if (busReset)
			longReq_reg <= 1'b0;
		else if (w && idx == spbr_pkg::IDX_GAP)
			longReq_reg <= wd[spbr_pkg::LBR_BIT];
	end

	// Gap count and its double-reset fallback
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			gap_reg   <= spbr_pkg::GAP_RESET;
			noUpd_reg <= 1'b0;
		end
		else if (w && idx == spbr_pkg::IDX_GAP)
		begin
			gap_reg   <= wd[5:0];
			noUpd_reg <= 1'b0;
		end
		else if (evt.phyCfgValid)
		begin
			gap_reg   <= evt.phyCfgGap;
			noUpd_reg <= 1'b0;
		end
		else if (busReset)
		begin
			if (noUpd_reg)
				gap_reg <= spbr_pkg::GAP_RESET;
			noUpd_reg <= 1'b1;
		end
	end

	// ****************************************************
	// Register 4: link, contender, power class
	// ****************************************************
	// Straps load once after reset, then software owns
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			linkAct_reg   <= spbr_pkg::LCTL_RESET;
			contend_reg   <= 1'b0;
			pwr_reg       <= 3'h0;
			strapDone_reg <= 1'b0;
		end
		else if (!strapDone_reg)
		begin
			contend_reg   <= contenderStrap;
			pwr_reg       <= powerClassStrap;
			strapDone_reg <= 1'b1;
		end
		else if (w && idx == spbr_pkg::IDX_LINK)
		begin
			linkAct_reg <= wd[spbr_pkg::LCTL_BIT];
			contend_reg <= wd[spbr_pkg::CONT_BIT];
			pwr_reg     <= wd[2:0];
		end
	end

	// ****************************************************
	// Register 5: enables and flags
	// ****************************************************
	logic w5; // Write to register 5
	assign w5 = w && idx == spbr_pkg::IDX_INTR;

	// Plain enables and short reset request
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			resEn_reg    <= 1'b0;
			eaa_reg      <= 1'b0;
			emc_reg      <= 1'b0;
			shortReq_reg <= 1'b0;
		end
		else
		begin
			if (w5)
			begin
				resEn_reg <= wd[spbr_pkg::RES_BIT];
				eaa_reg   <= wd[spbr_pkg::EAA_BIT];
				emc_reg   <= wd[spbr_pkg::EMC_BIT];
			end
			if (busReset)
				shortReq_reg <= 1'b0;
			else if (w5)
				shortReq_reg <= wd[spbr_pkg::SBR_BIT];
		end
	end

	// Sticky flags, write one clears, set wins
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			cfgTo_reg   <= 1'b0;
			stTo_reg    <= 1'b0;
			portEv_reg  <= 1'b0;
			cpDrop_reg  <= spbr_pkg::CPD_RESET;
			cpsPrev_reg <= 1'b0;
		end
		else
		begin
			cpsPrev_reg <= cablePowerSense;
			cfgTo_reg <= (cfgTo_reg &
				~(w5 & wd[spbr_pkg::CTO_BIT])) | evt.cfgTimeout;
			stTo_reg <= (stTo_reg &
				~(w5 & wd[spbr_pkg::STO_BIT])) | evt.stateTimeout;
			portEv_reg <= (portEv_reg &
				~(w5 & wd[spbr_pkg::PEV_BIT])) | evt.portEvent |
				(evt.resumeStart & resEn_reg);
			cpDrop_reg <= (cpDrop_reg &
				~(w5 & wd[spbr_pkg::CPD_BIT])) |
				(cpsPrev_reg & ~cablePowerSense);
		end
	end

	// ****************************************************
	// Register 7: page and port select
	// ****************************************************
	// Page choice steers the window
	always_ff @(posedge clk or negedge rstn_reg)
	begin
		if (!rstn_reg)
		begin
			page_reg <= 3'h0;
			port_reg <= 4'h0;
		end
		else if (w && idx == spbr_pkg::IDX_PAGE)
		begin
			page_reg <= wd[7:spbr_pkg::PAGE_LSB];
			port_reg <= wd[3:0];
		end
	end

	// ****************************************************
	// Submodules
	// ****************************************************
	// Paged window storage; reserved pages not written
	spbr_page_store u_page (
		.clk    (clk),
		.rstn   (rstn_reg),
		.wrEn   (wrFire & pagedHit & ~pageRsv),
		.slot   (slot),
		.idx    (idx[2:0]),
		.wrData (wd),
		.rdData (pageRd)
	);

	// Bus reset engine fed by requests
	spbr_reset_engine #(
		.LONG_CYCLES (LONG_CYCLES)
	) u_eng (
		.clk        (clk),
		.rstn       (rstn_reg),
		.req        ('{longReq: longReq_reg,
			shortReq: shortReq_reg, linkBusy: evt.linkBusy}),
		.active     (engAct),
		.isLong     (engLong),
		.startPulse (engStart)
	);

	// ****************************************************
	// Outputs
	// ****************************************************
	assign prdata        = {24'h000000, rdata_reg};
	assign pready        = ready_reg;
	assign pslverr       = err_reg;
	assign busResetDrive = engAct;
	assign busResetLong  = engLong;
	assign statusXfer    = xfer_reg;
	assign statusData    = xdata_reg;
	assign ctrl = '{linkActive: linkAct_reg,
		contender: contend_reg, powerClass: pwr_reg,
		rootHoldoff: holdoff_reg, gapCount: gap_reg,
		resumeEnable: resEn_reg, arbAccel: eaa_reg,
		multispeed: emc_reg, portSelect: port_reg,
		nodeIdValid: idValid_reg};
endmodule : spbr_top

/* testbench/spbr_assertions.sv */
// Port checker of the PHY register bank
`timescale 1ns/1ns
module spbr_assertions #(
	parameter int LONG_CYCLES = 50
) (
	input wire logic                 clk,
	input wire logic                 resetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 cablePowerSense,
	input wire logic                 twoPortStrap,
	input wire spbr_pkg::spbr_evt_t  evt,
	input wire spbr_pkg::spbr_ctrl_t ctrl,
	input wire logic                 busResetDrive,
	input wire logic                 busResetLong,
	input wire logic                 statusXfer,
	input wire logic [7:0]           statusData
);
	logic [15:0] cnt_reg; // Cycles the bus reset has been driven
	wire logic   rdOk = pready && !pwrite && !pslverr; // Good read
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Count drive length so the fall can be judged
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) cnt_reg <= '0;
		else cnt_reg <= busResetDrive ? cnt_reg + 16'h1 : 16'h0;
	// One wait state, then a single answer cycle
	sequence waitThenAnswer;
		!pready ##1 pready ##1 !pready;
	endsequence
	a_ready_one_wait: assert property (
		psel && $rose(penable) |-> waitThenAnswer)
		else $error("pready not after one wait state");
	a_reserved_zero: assert property (
		rdOk && paddr[5:2] == 4'h6 |-> prdata == 32'h0)
		else $error("reserved register read nonzero");
	a_port_count: assert property (
		rdOk && paddr[5:2] == 4'h2
		|-> prdata == (twoPortStrap ? 32'hE2 : 32'hE1))
		else $error("port count register wrong");
	a_speed_delay: assert property (
		rdOk && paddr[5:2] == 4'h3 |-> prdata == 32'h41)
		else $error("speed and delay register wrong");
	a_cps_mirror: assert property (
		rdOk && paddr[5:2] == 4'h0 |-> prdata[0] == $past(cablePowerSense))
		else $error("cable power bit wrong");
	a_status_xfer: assert property (
		evt.selfIdDone |=> statusXfer && ctrl.nodeIdValid
		&& statusData[7:2] == $past(evt.selfId))
		else $error("status transfer missing");
	a_id_invalid: assert property (
		evt.busResetSeen && !evt.selfIdDone |=> !ctrl.nodeIdValid)
		else $error("node id valid after bus reset");
	a_reset_idle: assert property (
		$rose(busResetDrive) |-> !$past(evt.linkBusy))
		else $error("bus reset during traffic");
	a_long_length: assert property (
		$fell(busResetDrive) && busResetLong |-> cnt_reg == LONG_CYCLES)
		else $error("long reset length wrong");
	a_short_length: assert property (
		$fell(busResetDrive) && !busResetLong
		|-> cnt_reg == spbr_pkg::SHORT_RESET_CYC)
		else $error("short reset length wrong");
endmodule : spbr_assertions
bind spbr_top spbr_assertions #(.LONG_CYCLES(LONG_CYCLES)) chk_u (.clk,
	.resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.cablePowerSense, .twoPortStrap, .evt, .ctrl, .busResetDrive,
	.busResetLong, .statusXfer, .statusData);

/* testbench/spbr_link_model.sv */
// Model of the cable-side event source of the register bank
`timescale 1ns/1ns
module spbr_link_model (
	input  wire logic           clk,
	output spbr_pkg::spbr_evt_t evt
);
	logic busyLvl; // Traffic in progress
	initial
	begin
		busyLvl = 1'b0;
		evt = '0;
	end
	task automatic ev(input spbr_pkg::spbr_evt_t v);
		@(posedge clk);
		v.linkBusy = busyLvl;
		evt <= v;
		@(posedge clk);
		evt <= '{linkBusy: busyLvl, default: '0};
	endtask : ev
	task automatic busy(input logic b);
		@(posedge clk);
		busyLvl = b;
		evt <= '{linkBusy: b, default: '0};
	endtask : busy
endmodule : spbr_link_model

/* testbench/tb_top.sv */
// Self-checking bench of the PHY register bank
`timescale 1ns/1ns
module tb_top;
	logic                 clk, resetn, psel, penable, pwrite, err;
	logic [7:0]           paddr, statusData;
	logic [31:0]          pwdata, prdata, rdv;
	logic [3:0]           pstrb;
	logic                 pready, pslverr, cablePowerSense, twoPortStrap;
	logic                 busResetDrive, busResetLong, statusXfer;
	spbr_pkg::spbr_evt_t  evt;
	spbr_pkg::spbr_ctrl_t ctrl;
	int                   n_fail, total_checks;
	spbr_top #(.LONG_CYCLES(50)) dut_u (.clk, .resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.cablePowerSense, .twoPortStrap, .contenderStrap(1'b1),
		.powerClassStrap(3'h5), .evt, .ctrl, .busResetDrive,
		.busResetLong, .statusXfer, .statusData);
	spbr_link_model lnk_u (.clk, .evt);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic end_of_test();
		if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; answer taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
		if (n == 20)
		begin
			n_fail++;
			end_of_test();
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), e, rdv);
	endtask : rd
	task automatic waitDrv(input logic v);
		int n;
		for (n = 0; n < 400 && busResetDrive !== v; n++) @(posedge clk);
		if (n == 400)
		begin
			n_fail++;
			end_of_test();
		end
	endtask : waitDrv
	// ****
	// Scenarios
	// ****
	task automatic sFixed();
		rd(8'h08, 32'hE2);
		apb(1'b1, 8'h08, 8'h00);
		rd(8'h08, 32'hE2);
		rd(8'h0C, 32'h41);
		rd(8'h10, 32'hC5);
		apb(1'b1, 8'h10, 8'hFF);
		rd(8'h10, 32'hC7);
		apb(1'b1, 8'h18, 8'hFF);
		rd(8'h18, 32'h0);
		twoPortStrap <= 1'b0;
		rd(8'h08, 32'hE1);
		rd(8'h04, 32'h3F);
		rd(8'h14, 32'h10);
		apb(1'b0, 8'h40, 8'h00);
		chk("pslverr", 32'h1, {31'h0, err});
	endtask : sFixed
	task automatic sPages();
		for (int p = 0; p < 8; p++)
		begin
			apb(1'b1, 8'h1C, {3'(p), 5'h1F});
			apb(1'b1, 8'h3C, 8'hA0 + 8'(p));
			rd(8'h1C, {24'h0, 3'(p), 5'h0F});
			rd(8'h3C, (p inside {[2:6]}) ? 32'h0 : 32'hA0 + p);
			rd(8'h0C, 32'h41);
		end
		apb(1'b1, 8'h1C, 8'h00);
		rd(8'h3C, 32'hA0);
	endtask : sPages
	task automatic sSelf();
		lnk_u.ev('{rootWon: 1'b1, default: '0});
		lnk_u.ev('{selfIdDone: 1'b1, selfId: 6'h15, default: '0});
		rd(8'h00, 32'h57);
		lnk_u.ev('{busResetSeen: 1'b1, default: '0});
		apb(1'b0, 8'h00, 8'h00);
		chk("root", 32'h1, rdv & 32'h3);
	endtask : sSelf
	task automatic sFlags();
		apb(1'b1, 8'h14, 8'h10);
		rd(8'h14, 32'h0);
		lnk_u.ev('{cfgTimeout: 1'b1, stateTimeout: 1'b1, portEvent: 1'b1,
			default: '0});
		rd(8'h14, 32'h2C);
		apb(1'b1, 8'h14, 8'h2C);
		rd(8'h14, 32'h0);
		apb(1'b1, 8'h14, 8'h83);
		lnk_u.ev('{resumeStart: 1'b1, default: '0});
		rd(8'h14, 32'h87);
		apb(1'b1, 8'h14, 8'h04);
		rd(8'h14, 32'h0);
		cablePowerSense <= 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h14, 32'h10);
		apb(1'b0, 8'h00, 8'h00);
		chk("cps", 32'h0, rdv & 32'h1);
	endtask : sFlags
	task automatic sGap();
		apb(1'b1, 8'h04, 8'h85);
		lnk_u.ev('{phyCfgValid: 1'b1, phyCfgGap: 6'h0A, default: '0});
		rd(8'h04, 32'h8A);
		lnk_u.ev('{busResetSeen: 1'b1, default: '0});
		rd(8'h04, 32'h8A);
		lnk_u.ev('{busResetSeen: 1'b1, default: '0});
		rd(8'h04, 32'hBF);
		chk("gap", 32'h3F, {26'h0, ctrl.gapCount});
	endtask : sGap
	task automatic sReset();
		lnk_u.busy(1'b1);
		apb(1'b1, 8'h04, 8'hC5);
		repeat (5) @(posedge clk);
		chk("drive", 32'h0, {31'h0, busResetDrive});
		lnk_u.busy(1'b0);
		waitDrv(1'b1);
		chk("long", 32'h1, {31'h0, busResetLong});
		rd(8'h04, 32'h85);
		waitDrv(1'b0);
		apb(1'b1, 8'h14, 8'h40);
		waitDrv(1'b1);
		chk("long", 32'h0, {31'h0, busResetLong});
		rd(8'h14, 32'h10);
		waitDrv(1'b0);
	endtask : sReset
	initial
	begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		cablePowerSense = 1'b1;
		twoPortStrap = 1'b1;
		n_fail = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		sFixed();
		sPages();
		sSelf();
		sFlags();
		sGap();
		sReset();
		end_of_test();
	end
endmodule : tb_top
